// File: pkg/mzad_pkg.sv
// package: types and constants of the memory zone address decoder
package mzad_pkg;
	typedef enum logic [1:0] {MZAD_CFG, MZAD_OTP, MZAD_DATA, MZAD_NONE} mzad_zone_t;
	typedef enum logic [1:0] {MZAD_RD, MZAD_WR, MZAD_WR_ENC, MZAD_VALIDATE} mzad_op_t;
	typedef enum logic [1:0] {MZAD_L4, MZAD_L32, MZAD_L36, MZAD_L72} mzad_len_t;

	localparam int          MZAD_MEM_BYTES   = 1400;
	localparam logic [10:0] MZAD_CFG_BASE    = 11'h000;
	localparam logic [10:0] MZAD_OTP_BASE    = 11'h080;
	localparam logic [10:0] MZAD_DATA_BASE   = 11'h0C0;
	localparam logic [10:0] MZAD_SLOT8_BASE  = 11'h120;
	localparam logic [10:0] MZAD_SLOT9_BASE  = 11'h2C0;
	localparam logic [10:0] MZAD_SMALL_BYTES = 11'h024;
	localparam logic [10:0] MZAD_SLOT8_BYTES = 11'h1A0;
	localparam logic [10:0] MZAD_BIG_BYTES   = 11'h048;
	localparam logic [3:0]  MZAD_SLOT8       = 4'h8;
	localparam logic [3:0]  MZAD_SLOT9       = 4'h9;
	localparam logic [3:0]  MZAD_SMALL_FULL  = 4'h1;
	localparam logic [2:0]  MZAD_SMALL_PART  = 3'h1;
	localparam logic [3:0]  MZAD_SLOT8_FULL  = 4'hD;
	localparam logic [2:0]  MZAD_SLOT8_PART  = 3'h0;
	localparam logic [3:0]  MZAD_BIG_FULL    = 4'h2;
	localparam logic [2:0]  MZAD_BIG_PART    = 3'h2;
	localparam logic [15:0] MZAD_WR_MASK     = 16'h9F94;
	localparam logic [15:0] MZAD_ENC_MASK    = 16'h4020;
	localparam logic [15:0] MZAD_RD_MASK     = 16'hDD04;
	localparam logic [6:0]  MZAD_KEY_PAD     = 7'h04;
	localparam logic [6:0]  MZAD_COORD       = 7'h20;
	localparam logic [6:0]  MZAD_KEY_GENERATE_CMD_PAD  = 7'h19;
	localparam logic [6:0]  MZAD_PRIV_LEN    = 7'h24;
	localparam logic [6:0]  MZAD_PUB_CMD_LEN = 7'h40;
	localparam logic [6:0]  MZAD_PUB_LEN     = 7'h48;
	localparam logic [3:0]  MZAD_KEY_INVALID = 4'hA;
	localparam logic [3:0]  MZAD_KEY_VALID   = 4'h5;
	localparam logic [7:0]  MZAD_ST_OK       = 8'h00;
	localparam logic [7:0]  MZAD_ST_PARSE    = 8'h03;
	localparam logic [7:0]  MZAD_ST_EXEC     = 8'h0F;

	function automatic logic [6:0] mzad_len_bytes(input mzad_len_t l);
		case (l)
			MZAD_L4:  mzad_len_bytes = MZAD_KEY_PAD;
			MZAD_L32: mzad_len_bytes = MZAD_COORD;
			MZAD_L36: mzad_len_bytes = MZAD_PRIV_LEN;
			default:  mzad_len_bytes = MZAD_PUB_LEN;
		endcase
	endfunction
endpackage

// File: pkg/mzad_link_if.sv
// interface: command link between the host end and the device end
`timescale 1ns/1ps
interface mzad_link_if;
	import mzad_pkg::*;
	logic        cmd_valid;
	logic        cmd_ready;
	mzad_op_t    cmd_op;
	mzad_zone_t  cmd_zone;
	logic [15:0] cmd_addr;
	mzad_len_t   cmd_len;
	logic        wr_valid;
	logic        wr_ready;
	logic [7:0]  wr_data;
	logic        rd_valid;
	logic [7:0]  rd_data;
	logic        rsp_valid;
	logic [7:0]  rsp_status;

	modport dev (
		input  cmd_valid, cmd_op, cmd_zone, cmd_addr, cmd_len, wr_valid, wr_data,
		output cmd_ready, wr_ready, rd_valid, rd_data, rsp_valid, rsp_status
	);
	modport host (
		output cmd_valid, cmd_op, cmd_zone, cmd_addr, cmd_len, wr_valid, wr_data,
		input  cmd_ready, wr_ready, rd_valid, rd_data, rsp_valid, rsp_status
	);
endinterface

// File: design/mzad_device.sv
// device end: zone address decode, permission check and key storage
`timescale 1ns/1ps
module mzad_device
	import mzad_pkg::*;
#(
	parameter logic [15:0] KEY_VALID_MASK = 16'hC000
) (
	input  wire logic        clock,
	input  wire logic        rst,
	mzad_link_if.dev         link,
	input  wire logic        prog_we,
	input  wire logic [10:0] prog_addr,
	input  wire logic [7:0]  prog_data,
	input  wire logic        hash_start,
	input  wire logic        hash_key_generate_cmd,
	input  wire logic [3:0]  hash_slot,
	output logic             hash_busy,
	output logic             hash_valid,
	output logic [7:0]       hash_data,
	output logic             hash_last
);
	typedef enum logic [2:0] {S_IDLE, S_READ, S_WRITE, S_RESP, S_HASH} mzad_dstate_t;

	function automatic logic [10:0] slot_base_f(input logic [3:0] s);
		logic [10:0] n;
		n = {7'h00, s - MZAD_SLOT9};
		if (s < MZAD_SLOT8)
			slot_base_f = {2'h0, s, 5'h00} + {5'h00, s, 2'h0};
		else if (s == MZAD_SLOT8)
			slot_base_f = MZAD_SLOT8_BASE;
		else
			slot_base_f = MZAD_SLOT9_BASE + {n[4:0], 6'h00} + {n[7:0], 3'h0};
	endfunction

	logic [7:0]   mem [MZAD_MEM_BYTES];
	mzad_dstate_t state_reg;
	mzad_dstate_t state_next;
	logic         cmd_ready_reg;
	logic         wr_ready_reg;
	logic         rd_valid_reg;
	logic [7:0]   rd_data_reg;
	logic         rsp_valid_reg;
	logic [7:0]   rsp_status_reg;
	logic         hash_busy_reg;
	logic         hash_valid_reg;
	logic [7:0]   hash_data_reg;
	logic         hash_last_reg;
	logic [6:0]   cnt_reg;
	logic [6:0]   nbytes_reg;
	logic [10:0]  ptr_reg;
	logic [10:0]  hbase_reg;
	logic         hgen_reg;
	logic         key_slot_reg;

	logic [3:0]   slot;
	logic [2:0]   woff;
	logic [3:0]   blk;
	logic [3:0]   full_blks;
	logic [2:0]   part_words;
	logic [10:0]  slot_size;
	logic [6:0]   nbytes;
	logic         is_word;
	logic [10:0]  word_b;
	logic [10:0]  in_off;
	logic [10:0]  start;
	logic         geom_ok;
	logic         shape_ok;
	logic         perm_ok;
	logic         acc_ok;
	logic         cmd_take;
	logic         hash_take;
	logic         wr_take;
	logic         step;
	logic         last_byte;
	logic [6:0]   hoff;
	logic [6:0]   hidx;
	logic         hash_pad;
	logic [10:0]  mem_ra;
	logic [7:0]   mem_q;
	logic         fsm_we;
	logic         mem_we;
	logic [10:0]  mem_wa;
	logic [7:0]   mem_wd;

	// decode of the 16-bit word address; unused high bits never reach logic
	assign slot = link.cmd_addr[6:3];
	assign woff = link.cmd_addr[2:0];
	assign blk = (slot < MZAD_SLOT8) ? {3'h0, link.cmd_addr[8]} :
		(slot == MZAD_SLOT8) ? link.cmd_addr[11:8] : {2'h0, link.cmd_addr[9:8]};
	assign full_blks = (slot < MZAD_SLOT8) ? MZAD_SMALL_FULL :
		(slot == MZAD_SLOT8) ? MZAD_SLOT8_FULL : MZAD_BIG_FULL;
	assign part_words = (slot < MZAD_SLOT8) ? MZAD_SMALL_PART :
		(slot == MZAD_SLOT8) ? MZAD_SLOT8_PART : MZAD_BIG_PART;
	assign slot_size = (slot < MZAD_SLOT8) ? MZAD_SMALL_BYTES :
		(slot == MZAD_SLOT8) ? MZAD_SLOT8_BYTES : MZAD_BIG_BYTES;
	assign nbytes = mzad_len_bytes(link.cmd_len);
	assign is_word = link.cmd_len == MZAD_L4;
	// a 32-byte move covers the whole block, so the word field is ignored
	assign word_b = is_word ? {6'h00, woff, 2'h0} : 11'h000;
	assign in_off = {2'h0, blk, 5'h00} + word_b;

	always_comb begin
		case (link.cmd_zone)
			MZAD_CFG: start = MZAD_CFG_BASE + {4'h0, link.cmd_addr[4:3], 5'h00} + word_b;
			MZAD_OTP: start = MZAD_OTP_BASE + {5'h00, link.cmd_addr[3], 5'h00} + word_b;
			default:  start = MZAD_DATA_BASE + slot_base_f(slot) + in_off;
		endcase
	end

	// key sized moves (36 private, 72 public) start at the slot's first byte
	always_comb begin
		case (link.cmd_len)
			MZAD_L4:  geom_ok = (blk < full_blks) || (blk == full_blks && woff < part_words);
			MZAD_L32: geom_ok = blk < full_blks;
			default:  geom_ok = blk == 4'h0 && woff == 3'h0 && {4'h0, nbytes} <= slot_size;
		endcase
	end

	always_comb begin
		case (link.cmd_op)
			MZAD_RD:     perm_ok = link.cmd_zone != MZAD_DATA || MZAD_RD_MASK[slot];
			MZAD_WR:     perm_ok = link.cmd_zone == MZAD_DATA && MZAD_WR_MASK[slot];
			MZAD_WR_ENC: perm_ok = link.cmd_zone == MZAD_DATA && MZAD_ENC_MASK[slot];
			default:     perm_ok = link.cmd_zone == MZAD_DATA && KEY_VALID_MASK[slot] &&
				in_off == 11'h000;
		endcase
	end

	assign shape_ok = (link.cmd_zone == MZAD_DATA) ? geom_ok :
		(link.cmd_zone != MZAD_NONE) && (is_word || link.cmd_len == MZAD_L32);
	assign acc_ok = shape_ok && perm_ok;

	assign cmd_take = state_reg == S_IDLE && cmd_ready_reg && link.cmd_valid;
	assign hash_take = state_reg == S_IDLE && !link.cmd_valid && hash_start &&
		hash_slot >= MZAD_SLOT8;
	assign wr_take = state_reg == S_WRITE && wr_ready_reg && link.wr_valid;
	assign step = state_reg == S_READ || state_reg == S_HASH || wr_take;
	assign last_byte = cnt_reg == nbytes_reg - 7'h01;

	// hash feed: stored layout as is, or pads then X then Y for key generation
	assign hoff = cnt_reg - MZAD_KEY_GENERATE_CMD_PAD;
	assign hash_pad = hgen_reg && cnt_reg < MZAD_KEY_GENERATE_CMD_PAD;
	assign hidx = !hgen_reg ? cnt_reg :
		(hoff < MZAD_COORD) ? hoff + MZAD_KEY_PAD : hoff + MZAD_KEY_PAD + MZAD_KEY_PAD;
	assign mem_ra = (state_reg == S_HASH) ? hbase_reg + {4'h0, hidx} :
		(state_reg == S_IDLE) ? start : ptr_reg;
	assign mem_q = mem[mem_ra];

	// a rejected command never raises fsm_we, so memory stays untouched
	assign fsm_we = wr_take || (cmd_take && acc_ok && link.cmd_op == MZAD_VALIDATE);
	assign mem_we = fsm_we || prog_we;
	assign mem_wa = wr_take ? ptr_reg : fsm_we ? start : prog_addr;
	assign mem_wd = !fsm_we ? prog_data :
		!wr_take ? {MZAD_KEY_VALID, mem_q[3:0]} :
		(cnt_reg == 7'h00 && key_slot_reg) ? {MZAD_KEY_INVALID, link.wr_data[3:0]} :
		link.wr_data;

	// provisioning writes lose to link writes in the same cycle
	always_ff @(posedge clock) begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE: begin
				if (cmd_take) begin
					if (!acc_ok || link.cmd_op == MZAD_VALIDATE)
						state_next = S_RESP;
					else if (link.cmd_op == MZAD_RD)
						state_next = S_READ;
					else
						state_next = S_WRITE;
				end else if (hash_take) begin
					state_next = S_HASH;
				end
			end
			S_READ:  state_next = last_byte ? S_RESP : S_READ;
			S_WRITE: state_next = (wr_take && last_byte) ? S_RESP : S_WRITE;
			S_HASH:  state_next = last_byte ? S_IDLE : S_HASH;
			default: state_next = S_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg      <= S_IDLE;
			cmd_ready_reg  <= 1'b0;
			wr_ready_reg   <= 1'b0;
			rd_valid_reg   <= 1'b0;
			rd_data_reg    <= 8'h00;
			rsp_valid_reg  <= 1'b0;
			rsp_status_reg <= MZAD_ST_OK;
			hash_busy_reg  <= 1'b0;
			hash_valid_reg <= 1'b0;
			hash_data_reg  <= 8'h00;
			hash_last_reg  <= 1'b0;
		end else begin
			state_reg      <= state_next;
			cmd_ready_reg  <= state_next == S_IDLE;
			wr_ready_reg   <= state_next == S_WRITE;
			rd_valid_reg   <= state_reg == S_READ;
			rd_data_reg    <= mem_q;
			rsp_valid_reg  <= state_reg == S_RESP;
			hash_busy_reg  <= state_next == S_HASH;
			hash_valid_reg <= state_reg == S_HASH;
			hash_data_reg  <= hash_pad ? 8'h00 : mem_q;
			hash_last_reg  <= state_reg == S_HASH && last_byte;
			if (cmd_take)
				rsp_status_reg <= acc_ok ? MZAD_ST_OK : shape_ok ? MZAD_ST_EXEC : MZAD_ST_PARSE;
		end
	end

	// encrypted payloads are stored as delivered, except that a key slot's first byte gets MZAD_KEY_INVALID in its top nibble; decryption sits upstream
	always_ff @(posedge clock) begin
		if (rst) begin
			cnt_reg      <= 7'h00;
			nbytes_reg   <= 7'h01;
			ptr_reg      <= 11'h000;
			hbase_reg    <= 11'h000;
			hgen_reg     <= 1'b0;
			key_slot_reg <= 1'b0;
		end else if (state_reg == S_IDLE) begin
			cnt_reg <= 7'h00;
			if (cmd_take) begin
				nbytes_reg   <= nbytes;
				ptr_reg      <= start;
				key_slot_reg <= link.cmd_zone == MZAD_DATA && KEY_VALID_MASK[slot] &&
					in_off == 11'h000;
			end else if (hash_take) begin
				hgen_reg   <= hash_key_generate_cmd;
				hbase_reg  <= MZAD_DATA_BASE + slot_base_f(hash_slot);
				nbytes_reg <= hash_key_generate_cmd ? MZAD_KEY_GENERATE_CMD_PAD + MZAD_PUB_CMD_LEN : MZAD_PUB_LEN;
			end
		end else if (step) begin
			cnt_reg <= cnt_reg + 7'h01;
			ptr_reg <= ptr_reg + 11'h001;
		end
	end

	assign link.cmd_ready  = cmd_ready_reg;
	assign link.wr_ready   = wr_ready_reg;
	assign link.rd_valid   = rd_valid_reg;
	assign link.rd_data    = rd_data_reg;
	assign link.rsp_valid  = rsp_valid_reg;
	assign link.rsp_status = rsp_status_reg;
	assign hash_busy       = hash_busy_reg;
	assign hash_valid      = hash_valid_reg;
	assign hash_data       = hash_data_reg;
	assign hash_last       = hash_last_reg;
endmodule

// File: design/mzad_host.sv
// host end: issues zone commands and converts key layouts
`timescale 1ns/1ps
module mzad_host
	import mzad_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	mzad_link_if.host        link,
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire mzad_op_t    req_op,
	input  wire mzad_zone_t  req_zone,
	input  wire logic [15:0] req_addr,
	input  wire mzad_len_t   req_len,
	input  wire logic        req_key,
	input  wire logic        wd_valid,
	output logic             wd_ready,
	input  wire logic [7:0]  wd_data,
	output logic             rdo_valid,
	output logic [7:0]       rdo_data,
	output logic             done,
	output logic [7:0]       done_status
);
	typedef enum logic [1:0] {H_IDLE, H_CMD, H_WRITE, H_WAIT} mzad_hstate_t;

	mzad_hstate_t state_reg;
	logic         req_ready_reg;
	logic         wd_ready_reg;
	logic         rdo_valid_reg;
	logic [7:0]   rdo_data_reg;
	logic         done_reg;
	logic [7:0]   done_status_reg;
	logic         cmd_valid_reg;
	mzad_op_t     op_reg;
	mzad_zone_t   zone_reg;
	logic [15:0]  addr_reg;
	mzad_len_t    len_reg;
	logic         key_reg;
	logic         wr_valid_reg;
	logic [7:0]   wr_data_reg;
	logic [6:0]   cnt_reg;

	logic         req_take;
	logic         req_wr;
	logic         local_bad;
	logic         pad_pos;
	logic         more;

	assign req_take = state_reg == H_IDLE && req_ready_reg && req_valid;
	assign req_wr = req_op == MZAD_WR || req_op == MZAD_WR_ENC;
	// refuse locally what the device would refuse anyway, saving a link round trip
	assign local_bad = req_zone == MZAD_NONE || (req_zone != MZAD_DATA &&
		(req_op != MZAD_RD || req_len == MZAD_L36 || req_len == MZAD_L72));
	// pads sit at 0-3 and, for a public key, 36-39; zero going out, dropped coming in
	assign pad_pos = key_reg && (cnt_reg < MZAD_KEY_PAD || (len_reg == MZAD_L72 &&
		cnt_reg >= MZAD_KEY_PAD + MZAD_COORD && cnt_reg < MZAD_KEY_PAD + MZAD_PRIV_LEN));
	assign more = cnt_reg < mzad_len_bytes(len_reg);

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg       <= H_IDLE;
			req_ready_reg   <= 1'b0;
			wd_ready_reg    <= 1'b0;
			rdo_valid_reg   <= 1'b0;
			rdo_data_reg    <= 8'h00;
			done_reg        <= 1'b0;
			done_status_reg <= MZAD_ST_OK;
			cmd_valid_reg   <= 1'b0;
			op_reg          <= MZAD_RD;
			zone_reg        <= MZAD_CFG;
			addr_reg        <= 16'h0000;
			len_reg         <= MZAD_L4;
			key_reg         <= 1'b0;
			wr_valid_reg    <= 1'b0;
			wr_data_reg     <= 8'h00;
			cnt_reg         <= 7'h00;
		end else begin
			done_reg      <= 1'b0;
			rdo_valid_reg <= 1'b0;
			case (state_reg)
				H_IDLE: begin
					req_ready_reg <= !req_take;
					cnt_reg       <= 7'h00;
					if (req_take) begin
						op_reg   <= req_op;
						zone_reg <= req_zone;
						addr_reg <= req_addr;
						len_reg  <= req_len;
						key_reg  <= req_key;
						if (local_bad) begin
							done_reg        <= 1'b1;
							done_status_reg <= MZAD_ST_PARSE;
						end else begin
							cmd_valid_reg <= 1'b1;
							state_reg     <= H_CMD;
						end
					end
				end
				H_CMD: begin
					if (link.cmd_ready) begin
						cmd_valid_reg <= 1'b0;
						state_reg     <= (op_reg == MZAD_WR || op_reg == MZAD_WR_ENC) ?
							H_WRITE : H_WAIT;
					end
				end
				H_WRITE: begin
					if (wr_valid_reg) begin
						if (link.wr_ready) begin
							wr_valid_reg <= 1'b0;
							cnt_reg      <= cnt_reg + 7'h01;
						end
					end else if (more && pad_pos) begin
						wr_valid_reg <= 1'b1;
						wr_data_reg  <= 8'h00;
					end else if (more) begin
						wd_ready_reg <= !(wd_ready_reg && wd_valid);
						if (wd_ready_reg && wd_valid) begin
							wr_valid_reg <= 1'b1;
							wr_data_reg  <= wd_data;
						end
					end
					if (link.rsp_valid) begin
						wd_ready_reg    <= 1'b0;
						wr_valid_reg    <= 1'b0;
						done_reg        <= 1'b1;
						done_status_reg <= link.rsp_status;
						req_ready_reg   <= 1'b1;
						state_reg       <= H_IDLE;
					end
				end
				default: begin
					if (link.rd_valid) begin
						rdo_valid_reg <= !pad_pos;
						rdo_data_reg  <= link.rd_data;
						cnt_reg       <= cnt_reg + 7'h01;
					end
					if (link.rsp_valid) begin
						done_reg        <= 1'b1;
						done_status_reg <= link.rsp_status;
						req_ready_reg   <= 1'b1;
						state_reg       <= H_IDLE;
					end
				end
			endcase
		end
	end

	assign link.cmd_valid = cmd_valid_reg;
	assign link.cmd_op    = op_reg;
	assign link.cmd_zone  = zone_reg;
	assign link.cmd_addr  = addr_reg;
	assign link.cmd_len   = len_reg;
	assign link.wr_valid  = wr_valid_reg;
	assign link.wr_data   = wr_data_reg;
	assign req_ready      = req_ready_reg;
	assign wd_ready       = wd_ready_reg;
	assign rdo_valid      = rdo_valid_reg;
	assign rdo_data       = rdo_data_reg;
	assign done           = done_reg;
	assign done_status    = done_status_reg;
endmodule

// File: tb/mzad_assertions.sv
// checker: link timing, decode and permission properties
`timescale 1ns/1ps
module mzad_assertions
	import mzad_pkg::*;
(
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        cmd_valid,
	input wire logic        cmd_ready,
	input wire mzad_op_t    cmd_op,
	input wire mzad_zone_t  cmd_zone,
	input wire logic [15:0] cmd_addr,
	input wire mzad_len_t   cmd_len,
	input wire logic        wr_valid,
	input wire logic        wr_ready,
	input wire logic        rd_valid,
	input wire logic        rsp_valid,
	input wire logic [7:0]  rsp_status
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	wire       take = cmd_valid && cmd_ready;
	wire [3:0] slot = cmd_addr[6:3];
	// block 0 word reads and writes are valid in every slot, so only permission decides
	wire       d4   = take && cmd_zone == MZAD_DATA && cmd_len == MZAD_L4;
	wire       b0   = cmd_addr[15:8] == 8'h00;
	wire       dget = d4 && cmd_op == MZAD_RD;
	wire       dput = d4 && cmd_op == MZAD_WR && b0;
	wire [6:0] need = cmd_len == MZAD_L4 ? 7'h04 : cmd_len == MZAD_L32 ? 7'h20 :
		cmd_len == MZAD_L36 ? 7'h24 : 7'h48;
	wire       step = rd_valid || (wr_valid && wr_ready);
	logic [6:0] cnt_reg;
	logic [6:0] need_reg;
	logic       data_reg;
	// link bytes since the last take; validate moves none
	always_ff @(posedge clock) begin
		cnt_reg <= (rst || take) ? 7'h00 : cnt_reg + {6'h00, step};
	end
	always_ff @(posedge clock) begin
		if (take) begin
			need_reg <= need;
			data_reg <= cmd_op != MZAD_VALIDATE;
		end
	end
	a_cfg_read_four: assert property (take && cmd_op == MZAD_RD && cmd_zone == MZAD_CFG &&
		cmd_len == MZAD_L4 |-> ##2 rd_valid [*4] ##1 (rsp_valid && rsp_status == 8'h00))
		else $error("config word read not four bytes then ok");
	a_xfer_count_len: assert property (rsp_valid && rsp_status == 8'h00 && data_reg |->
		cnt_reg == need_reg)
		else $error("byte count differs from length");
	a_write_refused: assert property (dput && !MZAD_WR_MASK[slot] |->
		##1 !wr_ready ##1 (rsp_valid && rsp_status == 8'h0F))
		else $error("clear write to locked slot not refused");
	a_write_granted: assert property (dput && MZAD_WR_MASK[slot] |-> ##1 wr_ready)
		else $error("clear write to open slot not started");
	a_enc_refused: assert property (d4 && b0 && cmd_op == MZAD_WR_ENC &&
		!MZAD_ENC_MASK[slot] |-> ##2 (rsp_valid && rsp_status == 8'h0F))
		else $error("encrypted write to locked slot not refused");
	a_read_refused: assert property (dget && b0 && !MZAD_RD_MASK[slot] |->
		##1 !rd_valid ##1 (!rd_valid && rsp_valid && rsp_status == 8'h0F))
		else $error("read of locked slot not refused");
	a_slot8_bad_block: assert property (dget && slot == 4'h8 && cmd_addr[11:8] > 4'hC |->
		##2 (rsp_valid && rsp_status == 8'h03))
		else $error("slot 8 block beyond C accepted");
	a_small_tail_bad: assert property (dget && slot == 4'h2 && cmd_addr[8] &&
		cmd_addr[2:0] != 3'h0 |-> ##2 (rsp_valid && rsp_status == 8'h03))
		else $error("small slot tail word accepted");
	a_big_tail_bad: assert property (dget && slot > 4'h8 && MZAD_RD_MASK[slot] &&
		cmd_addr[9:8] == 2'h2 && cmd_addr[2:0] > 3'h1 |-> ##2 (rsp_valid && rsp_status == 8'h03))
		else $error("large slot tail word accepted");
endmodule

// File: tb/tb.sv
// testbench: host and device ends joined over the link, scoreboarded
`timescale 1ns/1ps
module tb;
	import mzad_pkg::*;
	localparam logic [15:0] RD_OK = 16'hDD04;
	localparam logic [15:0] WR_OK = 16'h9F94;
	localparam logic [15:0] EN_OK = 16'h4020;
	localparam logic [15:0] KEYS  = 16'hC000;
	logic        clock, rst, prog_we, hash_start, hash_key_generate_cmd, hash_busy, hash_valid, hash_last;
	logic        req_valid, req_ready, req_key, wd_valid, wd_ready, rdo_valid, done;
	logic [10:0] prog_addr;
	logic [7:0]  prog_data, hash_data, wd_data, rdo_data, done_status;
	logic [3:0]  hash_slot;
	mzad_op_t    req_op;
	mzad_zone_t  req_zone;
	logic [15:0] req_addr, a, hi;
	mzad_len_t   req_len;
	int          n_fail, num_checks, cycles;
	logic [7:0]  mem [MZAD_MEM_BYTES];
	logic [7:0]  rq [$], sq [$], wq [$], hq [$];
	logic [23:0] gt [10] = '{24'h210000, 24'h211003, 24'h210103, 24'h8C7000, 24'h8C0100,
		24'h8D0003, 24'hA21000, 24'hA22003, 24'hA10100, 24'hA30003};
	mzad_link_if link ();
	mzad_device mzad_device_i (.clock(clock), .rst(rst), .link(link), .prog_we(prog_we),
		.prog_addr(prog_addr), .prog_data(prog_data), .hash_start(hash_start),
		.hash_key_generate_cmd(hash_key_generate_cmd), .hash_slot(hash_slot), .hash_busy(hash_busy),
		.hash_valid(hash_valid), .hash_data(hash_data), .hash_last(hash_last));
	mzad_host mzad_host_i (.clock(clock), .rst(rst), .link(link), .req_valid(req_valid),
		.req_ready(req_ready), .req_op(req_op), .req_zone(req_zone), .req_addr(req_addr),
		.req_len(req_len), .req_key(req_key), .wd_valid(wd_valid), .wd_ready(wd_ready),
		.wd_data(wd_data), .rdo_valid(rdo_valid), .rdo_data(rdo_data), .done(done),
		.done_status(done_status));
	mzad_assertions mzad_assertions_i (.clock(clock), .rst(rst), .cmd_valid(link.cmd_valid),
		.cmd_ready(link.cmd_ready), .cmd_op(link.cmd_op), .cmd_zone(link.cmd_zone),
		.cmd_addr(link.cmd_addr), .cmd_len(link.cmd_len), .wr_valid(link.wr_valid),
		.wr_ready(link.wr_ready), .rd_valid(link.rd_valid), .rsp_valid(link.rsp_valid),
		.rsp_status(link.rsp_status));
	task automatic check(logic [7:0] seen, logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// byte position from the zone layouts, kept apart from the design's own map
	function automatic int lin(mzad_zone_t z, logic [15:0] x, mzad_len_t l);
		int off;
		off = (l == MZAD_L4) ? x[2:0] * 4 : 0;
		if (z == MZAD_CFG)
			return x[4:3] * 32 + off;
		if (z == MZAD_OTP)
			return MZAD_OTP_BASE + x[3] * 32 + off;
		if (x[6:3] < 8)
			return MZAD_DATA_BASE + x[6:3] * 36 + x[8] * 32 + off;
		if (x[6:3] == 8)
			return MZAD_DATA_BASE + MZAD_SLOT8_BASE + x[11:8] * 32 + off;
		return MZAD_DATA_BASE + MZAD_SLOT9_BASE + (x[6:3] - 9) * 72 + x[9:8] * 32 + off;
	endfunction
	task automatic req(mzad_op_t op, mzad_zone_t z, logic [15:0] x, mzad_len_t l, logic k,
		logic [7:0] st);
		int n;
		int b;
		logic p;
		logic [7:0] v;
		logic [7:0] fb [$];
		n = (l == MZAD_L4) ? 4 : (l == MZAD_L32) ? 32 : (l == MZAD_L36) ? 36 : 72;
		b = lin(z, x, l);
		sq.push_back(st);
		for (int i = 0; i < n && st == 8'h00; i++) begin
			p = k && i % 36 < 4;
			v = p ? 8'h00 : 8'($urandom);
			if (op == MZAD_RD && !p)
				rq.push_back(mem[b + i]);
			if (op == MZAD_WR || op == MZAD_WR_ENC) begin
				if (!p)
					fb.push_back(v);
				wq.push_back(v);
				mem[b + i] = (i == 0 && KEYS[x[6:3]]) ? {MZAD_KEY_INVALID, v[3:0]} : v;
			end
		end
		if (op == MZAD_VALIDATE && st == 8'h00)
			mem[b][7:4] = MZAD_KEY_VALID;
		@(negedge clock);
		req_valid = 1'b1;
		req_op = op;
		req_zone = z;
		req_addr = x;
		req_len = l;
		req_key = k;
		do @(posedge clock); while (!req_ready);
		@(negedge clock);
		req_valid = 1'b0;
		foreach (fb[i]) begin
			wd_valid = 1'b1;
			wd_data = fb[i];
			do @(posedge clock); while (!wd_ready);
			@(negedge clock);
		end
		wd_valid = 1'b0;
		do @(posedge clock); while (!done);
	endtask
	task automatic hash(logic g, logic [3:0] s);
		int b;
		int w;
		b = MZAD_DATA_BASE + MZAD_SLOT9_BASE + (s - 9) * 72;
		if (g)
			repeat (25) hq.push_back(8'h00);
		for (int i = 0; i < 72; i++)
			if (!g || i % 36 > 3)
				hq.push_back(mem[b + i]);
		@(negedge clock);
		hash_key_generate_cmd = g;
		hash_slot = s;
		hash_start = 1'b1;
		@(negedge clock);
		hash_start = 1'b0;
		check(8'(hash_busy), 8'h01);
		for (w = 0; w < 200 && !hash_last; w++)
			@(posedge clock);
		@(negedge clock);
		check(8'(hash_busy), 8'h00);
		check(8'(hq.size()), 8'h00);
	endtask
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// queues are filled before each request is driven, so popping here never races them
	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			n_fail++;
			results();
		end
		if (rdo_valid)
			check(rdo_data, rq.size() ? rq.pop_front() : 8'hXX);
		if (done)
			check(done_status, sq.size() ? sq.pop_front() : 8'hXX);
		if (link.wr_valid && link.wr_ready)
			check(link.wr_data, wq.size() ? wq.pop_front() : 8'hXX);
		if (hash_valid)
			check(hash_data, hq.size() ? hq.pop_front() : 8'hXX);
	end
	initial begin
		{rst, prog_we, hash_start, hash_key_generate_cmd, req_valid, req_key, wd_valid} = 7'h7F & 7'h40;
		{prog_addr, prog_data, hash_slot, req_addr, wd_data} = '0;
		req_op = MZAD_RD;
		req_zone = MZAD_CFG;
		req_len = MZAD_L4;
		{n_fail, num_checks, cycles} = '0;
		void'($urandom(94));
		repeat (8) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		for (int i = 0; i < MZAD_MEM_BYTES; i++) begin
			mem[i] = 8'($urandom);
			prog_we = 1'b1;
			prog_addr = 11'(i);
			prog_data = mem[i];
			@(negedge clock);
		end
		prog_we = 1'b0;
		for (int i = 0; i < 8; i++) begin
			a = {11'($urandom), i[1:0], 3'($urandom)};
			req(MZAD_RD, MZAD_CFG, a, mzad_len_t'(i[2]), 1'b0, 8'h00);
			req(MZAD_RD, MZAD_OTP, a, mzad_len_t'(i[2]), 1'b0, 8'h00);
		end
		req(MZAD_WR, MZAD_CFG, 16'h0000, MZAD_L4, 1'b0, 8'h03);
		req(MZAD_WR_ENC, MZAD_OTP, 16'h0008, MZAD_L4, 1'b0, 8'h03);
		req(MZAD_RD, MZAD_CFG, 16'h0000, MZAD_L36, 1'b0, 8'h03);
		req(MZAD_RD, MZAD_NONE, 16'h0000, MZAD_L4, 1'b0, 8'h03);
		$display("zone reads and local refusals done");
		for (int s = 0; s < 16; s++) begin
			a = {9'h000, 4'(s), 3'h0};
			req(MZAD_RD, MZAD_DATA, a, MZAD_L4, 1'b0, RD_OK[s] ? 8'h00 : 8'h0F);
			req(MZAD_WR, MZAD_DATA, a, MZAD_L4, 1'b0, WR_OK[s] ? 8'h00 : 8'h0F);
			req(MZAD_WR_ENC, MZAD_DATA, a, MZAD_L4, 1'b0, EN_OK[s] ? 8'h00 : 8'h0F);
		end
		$display("slot permissions done");
		// unused high address bits are randomised: they must not change the decode
		foreach (gt[i]) begin
			hi = gt[i][23:20] < 8 ? 16'hFE80 : gt[i][23:20] == 8 ? 16'hF080 : 16'hFC80;
			a = (16'($urandom) & hi) | {4'h0, gt[i][19:16], 1'b0, gt[i][23:20], gt[i][14:12]};
			req(MZAD_RD, MZAD_DATA, a, mzad_len_t'(gt[i][9:8]), 1'b0, gt[i][7:0]);
		end
		$display("slot geometry done");
		req(MZAD_WR, MZAD_DATA, 16'h0078, MZAD_L72, 1'b1, 8'h00);
		req(MZAD_RD, MZAD_DATA, 16'h0078, MZAD_L72, 1'b1, 8'h00);
		req(MZAD_RD, MZAD_DATA, 16'h0078, MZAD_L4, 1'b0, 8'h00);
		hash(1'b0, 4'hF);
		hash(1'b1, 4'hF);
		req(MZAD_VALIDATE, MZAD_DATA, 16'h0078, MZAD_L4, 1'b0, 8'h00);
		req(MZAD_RD, MZAD_DATA, 16'h0078, MZAD_L4, 1'b0, 8'h00);
		req(MZAD_WR_ENC, MZAD_DATA, 16'h0070, MZAD_L36, 1'b1, 8'h00);
		req(MZAD_RD, MZAD_DATA, 16'h0070, MZAD_L32, 1'b0, 8'h00);
		$display("key layouts done");
		repeat (4) @(posedge clock);
		results();
	end
endmodule
